// *** prs_defines.svh ***
// prs_defines.svh: constants of the position range and scaling block
// assumes inclusion by name from every design file that needs it
// ==========================================
// What this block does
// R1: range handling only in jog, profile, homing
// R2: absolute profile targets refer to zero point
// R3: zero valid only after homing reference or set
// R4: homing offers reference move and position set
// R5: leaving the range clears zero valid
// R6: continuous jog wraps at range bound, keeps counting
// R7: out-of-range step jog first zeroes position
// R8: out-of-range relative move first zeroes position
// R9: absolute move outside range is refused
// R10: internal resolution 32768 increments per revolution
// R11: only multiplier write activates new scaling
// R12: tiny ratio forbids moves leaving range
// R13: default scaling is 16384 units per revolution
// R14: multiplier signed 32 bit, 1..2147483647, default 1
// R15: scaling writes only with power stage off
// R16: divisor signed 32 bit, 1..2147483647, default 16384
// R17: internal factor may reduce user limit values
// R18: scaling changes movement, not stored user values
// R19: default lines: positive, negative, free, reference
// R20: travel switches only on lines one, two
// R21: free input levels readable in status
// R22: default range -1073741824 to 1073741823 units
// R23: wrap continues from opposite bound, two's complement
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH
`define PRS_ADDR_DEN  16'h060e
`define PRS_ADDR_NUM  16'h0610
`define PRS_ADDR_IO1  16'h0722
`define PRS_IO_SPAN   16'h0006
`define PRS_ADDR_POS  16'h0700
`define PRS_ADDR_FLAG 16'h0702
`define PRS_ADDR_FACT 16'h0704
`define PRS_ADDR_LINE 16'h0706
`define PRS_RST_NUM   32'h0000_0001
`define PRS_RST_DEN   32'h0000_4000
`define PRS_INC_SHIFT 31'h0
`define PRS_FRAC_BITS 16
`define PRS_FACT_ONE  32'h0001_0000
`define PRS_RST_FACT  32'h0002_0000
`define PRS_POS_MIN   32'hc000_0000
`define PRS_POS_MAX   32'h3fff_ffff
`define PRS_FN_FREE   16'h0001
`define PRS_FN_FAULT  16'h0002
`define PRS_FN_ENA    16'h0003
`define PRS_FN_HALT   16'h0004
`define PRS_FN_JOGP   16'h0009
`define PRS_FN_JOGN   16'h000a
`define PRS_FN_JOGFS  16'h000b
`define PRS_FN_REF    16'h0014
`define PRS_FN_POSITIVE_TRAVEL_SWITCH   16'h0015
`define PRS_FN_NEGATIVE_TRAVEL_SWITCH   16'h0016
`define PRS_FN_OFREE  16'h0065
`define PRS_FN_ONOF   16'h0066
`define PRS_FN_OACT   16'h0067
`endif

// *** prs_pkg.sv ***
// prs_pkg.sv: types of the position range and scaling block
// assumes nothing beyond a SystemVerilog compiler
package prs_pkg;
  typedef enum logic [1:0] {OPM_OTHER = 2'h0, OPM_JOG = 2'h1, OPM_PPOS = 2'h2, OPM_HOME = 2'h3} prs_mode_t;
  typedef enum logic [2:0] {MV_JOG_CONT = 3'h0, MV_JOG_STEP = 3'h1, MV_PP_REL = 3'h2,
                            MV_PP_ABS = 3'h3, MV_HOME_REF = 3'h4, MV_HOME_SET = 3'h5} prs_move_t;
  typedef enum logic [1:0] {SC_IDLE = 2'h1, SC_CALC = 2'h2} prs_scale_t;
endpackage

// *** prs_div.sv ***
// prs_div.sv: sequential restoring divider, one quotient bit per enabled clock
// assumes divisor nonzero and below 2**(W-1)
`timescale 1ns/1ns
`default_nettype none
module prs_div
#(
  parameter int W = 64
)
(
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic [W-1:0]      quotient
);
  localparam int CW = $clog2(W) + 1;
  logic [W-1:0]  rem;
  logic [W-1:0]  den;
  logic [CW-1:0] cnt;
  logic          busy;
  wire  [W-1:0]  shifted = {rem[W-2:0], quotient[W-1]};
  wire           fits    = shifted >= den;

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      busy     <= 1'h0;
      done     <= 1'h0;
      rem      <= '0;
      den      <= '0;
      cnt      <= '0;
      quotient <= '0;
    end
    else if (ce)
    begin
      done <= 1'h0;
      if (start)
      begin
        rem      <= '0;
        den      <= divisor;
        quotient <= dividend;
        cnt      <= CW'(W);
        busy     <= 1'h1;
      end
      else if (busy)
      begin
        rem      <= fits ? shifted - den : shifted;
        quotient <= {quotient[W-2:0], fits};
        cnt      <= cnt - CW'(1);
        if (cnt == CW'(1))
        begin
          busy <= 1'h0;
          done <= 1'h1;
        end
      end
    end
endmodule // prs_div
`default_nettype wire

// *** prs_top.sv ***
// prs_top.sv: position range, user scaling and local line functions
// assumes a parameter port from the fieldbus side, unit step pulses from motion
`timescale 1ns/1ns
`default_nettype none
`include "prs_defines.svh"
module prs_top
  import prs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        stage_on,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic             par_ack,
  output logic             par_err,
  output logic [31:0]      par_rdata,
  input  wire prs_mode_t   op_mode,
  input  wire logic        mv_req,
  input  wire prs_move_t   mv_kind,
  input  wire logic [31:0] mv_val,
  output logic             mv_ack,
  output logic             mv_refuse,
  output logic [31:0]      tgt_usr,
  output logic [31:0]      tgt_inc,
  input  wire logic        step,
  input  wire logic        step_neg,
  output logic [31:0]      pos_usr,
  output logic             zero_valid,
  output logic             halt_req,
  input  wire logic [3:0]  line_in,
  output logic [3:0]       local_line_state,
  output logic             positive_travel_switch,
  output logic             negative_travel_switch,
  output logic             ref_switch
);
  // ==========================================
  // storage
  logic [31:0] position_scale_multiplier;
  logic [31:0] position_scale_divisor;
  logic [31:0] act_den;
  logic [31:0] factor;
  logic [15:0] io_fn [4];
  prs_scale_t  sc_state;
  prs_scale_t  next_sc_state;
  logic        div_done;
  logic [63:0] div_quo;

  // ==========================================
  // parameter port decode
  wire [15:0] io_off   = par_addr - `PRS_ADDR_IO1;
  wire [1:0]  io_idx   = io_off[2:1];
  wire        hit_num  = par_addr == `PRS_ADDR_NUM;
  wire        hit_den  = par_addr == `PRS_ADDR_DEN;
  wire        hit_io   = (io_off <= `PRS_IO_SPAN) && !io_off[0];
  wire        hit_pos  = par_addr == `PRS_ADDR_POS;
  wire        hit_flag = par_addr == `PRS_ADDR_FLAG;
  wire        hit_fact = par_addr == `PRS_ADDR_FACT;
  wire        hit_line = par_addr == `PRS_ADDR_LINE;
  wire        rd_hit   = hit_num || hit_den || hit_io || hit_pos || hit_flag || hit_fact || hit_line;
  wire        wr_ok    = ce && par_wr;
  wire        calc     = sc_state == SC_CALC;
  wire        val_ok   = !par_wdata[31] && (par_wdata != 32'h0);
  wire        ratio_small = factor < `PRS_FACT_ONE;

  // scaling writes gated by power stage and value range
  wire num_take = wr_ok && hit_num && !stage_on && val_ok && !calc; // R11 R14 R15
  wire den_take = wr_ok && hit_den && !stage_on && val_ok; // R15 R16

  // line function writes
  wire [15:0] fn       = par_wdata[15:0];
  wire        fn_known = fn == `PRS_FN_FREE || fn == `PRS_FN_FAULT || fn == `PRS_FN_ENA
                      || fn == `PRS_FN_HALT || fn == `PRS_FN_JOGP || fn == `PRS_FN_JOGN
                      || fn == `PRS_FN_JOGFS || fn == `PRS_FN_REF || fn == `PRS_FN_POSITIVE_TRAVEL_SWITCH
                      || fn == `PRS_FN_NEGATIVE_TRAVEL_SWITCH || fn == `PRS_FN_OFREE || fn == `PRS_FN_ONOF
                      || fn == `PRS_FN_OACT;
  wire        fn_place = (fn != `PRS_FN_POSITIVE_TRAVEL_SWITCH || io_idx == 2'h0)
                      && (fn != `PRS_FN_NEGATIVE_TRAVEL_SWITCH || io_idx == 2'h1); // R20
  wire        io_take  = wr_ok && hit_io && !stage_on && fn_known && fn_place
                      && (par_wdata[31:16] == 16'h0);
  wire        wr_take  = num_take || den_take || io_take;

  wire [31:0] rd_mux = hit_num  ? position_scale_multiplier :
                       hit_den  ? position_scale_divisor :
                       hit_io   ? {16'h0, io_fn[io_idx]} :
                       hit_pos  ? pos_usr :
                       hit_flag ? {29'h0, ratio_small, calc, zero_valid} :
                       hit_fact ? factor :
                       hit_line ? {28'h0, local_line_state} : 32'h0;

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      par_ack   <= 1'h0;
      par_err   <= 1'h0;
      par_rdata <= 32'h0;
    end
    else if (ce)
    begin
      par_ack <= par_wr || par_rd;
      par_err <= par_wr ? !wr_take : (par_rd && !rd_hit);
      if (par_rd && !par_wr)
        par_rdata <= rd_mux;
    end

  // ==========================================
  // scaling and internal factor
  prs_div #(.W(64)) u_div
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .start    (num_take),
    .dividend ({2'h0, par_wdata[30:0], `PRS_INC_SHIFT}),
    .divisor  ({32'h0, position_scale_divisor}),
    .done     (div_done),
    .quotient (div_quo)
  );

  // truncation here is why user limits may shrink
  wire [31:0] next_factor = (div_quo[63:32] != 32'h0) ? 32'hffff_ffff : div_quo[31:0]; // R10 R17

  always_comb
    case (sc_state)
      SC_IDLE: next_sc_state = num_take ? SC_CALC : SC_IDLE;
      SC_CALC: next_sc_state = div_done ? SC_IDLE : SC_CALC;
      default: next_sc_state = SC_IDLE;
    endcase

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      position_scale_multiplier <= `PRS_RST_NUM; // R14
      position_scale_divisor    <= `PRS_RST_DEN; // R13 R16
      act_den                   <= `PRS_RST_DEN;
      factor                    <= `PRS_RST_FACT; // R13
      sc_state                  <= SC_IDLE;
    end
    else if (ce)
    begin
      sc_state <= next_sc_state;
      if (num_take)
      begin
        position_scale_multiplier <= par_wdata; // R11
        act_den                   <= position_scale_divisor;
      end
      if (den_take)
        position_scale_divisor <= par_wdata; // R11
      if (div_done)
        factor <= next_factor;
    end

  // ==========================================
  // movement range
  wire mode_ok  = op_mode != OPM_OTHER; // R1
  wire is_jog   = mv_kind == MV_JOG_CONT || mv_kind == MV_JOG_STEP;
  wire is_pp    = mv_kind == MV_PP_REL || mv_kind == MV_PP_ABS;
  wire is_home  = mv_kind == MV_HOME_REF || mv_kind == MV_HOME_SET; // R4
  wire is_rel   = mv_kind == MV_JOG_STEP || mv_kind == MV_PP_REL;
  wire kind_ok  = (is_jog && op_mode == OPM_JOG) || (is_pp && op_mode == OPM_PPOS)
               || (is_home && op_mode == OPM_HOME);
  wire signed [32:0] rel_sum = $signed({pos_usr[31], pos_usr}) + $signed({mv_val[31], mv_val});
  wire signed [32:0] lo      = $signed({1'h1, `PRS_POS_MIN});
  wire signed [32:0] hi      = $signed({1'h0, `PRS_POS_MAX});
  wire signed [32:0] val_x   = $signed({mv_val[31], mv_val});
  wire rel_in   = rel_sum >= lo && rel_sum <= hi; // R22
  wire val_in   = val_x >= lo && val_x <= hi; // R22
  wire rel_out  = is_rel && !rel_in;
  wire mv_bad   = !kind_ok || calc || (rel_out && ratio_small) // R12
               || (mv_kind == MV_PP_ABS && !val_in) // R9
               || (is_home && !val_in);
  wire mv_take  = ce && mv_req && !mv_bad;

  // absolute targets are taken as offsets from the zero point
  wire [31:0] next_tgt = is_rel ? (rel_out ? mv_val : rel_sum[31:0]) : // R2
                         (mv_kind == MV_JOG_CONT) ? pos_usr : mv_val;
  // conversion uses the active factor; stored user values stay untouched
  wire signed [64:0] inc_prod = $signed(next_tgt) * $signed({1'h0, factor}); // R18

  wire [31:0] step_sum  = step_neg ? pos_usr - 32'h1 : pos_usr + 32'h1;
  wire        step_wrap = mode_ok && (step_sum[31] != step_sum[30]);
  wire [31:0] step_pos  = mode_ok ? {step_sum[30], step_sum[30:0]} : step_sum; // R6 R23

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      mv_ack     <= 1'h0;
      mv_refuse  <= 1'h0;
      halt_req   <= 1'h0;
      pos_usr    <= 32'h0;
      zero_valid <= 1'h0;
      tgt_usr    <= 32'h0;
      tgt_inc    <= 32'h0;
    end
    else if (ce)
    begin
      mv_ack    <= mv_req && !mv_bad;
      mv_refuse <= mv_req && mv_bad;
      halt_req  <= step && step_wrap && ratio_small; // R12
      if (mv_take && rel_out)
        pos_usr <= 32'h0; // R7 R8
      else if (mv_take && is_home)
        pos_usr <= mv_val; // R4
      else if (step)
        pos_usr <= step_pos; // R6
      if (mv_take && is_home)
        zero_valid <= 1'h1; // R3
      else if ((mv_take && rel_out) || (step && step_wrap))
        zero_valid <= 1'h0; // R5
      if (mv_take)
      begin
        tgt_usr <= next_tgt;
        tgt_inc <= inc_prod[`PRS_FRAC_BITS+31:`PRS_FRAC_BITS];
      end
    end

  // ==========================================
  // local line functions
  logic [3:0] free_m;
  logic [3:0] ref_m;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_line
      assign free_m[gi] = io_fn[gi] == `PRS_FN_FREE;
      assign ref_m[gi]  = io_fn[gi] == `PRS_FN_REF;
    end
  endgenerate

  always_ff @(posedge core_clk)
    if (sys_rst)
    begin
      io_fn[0]               <= `PRS_FN_POSITIVE_TRAVEL_SWITCH; // R19
      io_fn[1]               <= `PRS_FN_NEGATIVE_TRAVEL_SWITCH; // R19
      io_fn[2]               <= `PRS_FN_FREE; // R19
      io_fn[3]               <= `PRS_FN_REF; // R19
      local_line_state       <= 4'h0;
      positive_travel_switch <= 1'h0;
      negative_travel_switch <= 1'h0;
      ref_switch             <= 1'h0;
    end
    else if (ce)
    begin
      if (io_take)
        io_fn[io_idx] <= fn;
      local_line_state       <= line_in & free_m; // R21
      positive_travel_switch <= line_in[0] && io_fn[0] == `PRS_FN_POSITIVE_TRAVEL_SWITCH; // R20
      negative_travel_switch <= line_in[1] && io_fn[1] == `PRS_FN_NEGATIVE_TRAVEL_SWITCH; // R20
      ref_switch             <= |(line_in & ref_m);
    end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rel_take;
    ce && mv_req && !mv_bad && mv_kind == MV_PP_REL && rel_out;
  endsequence
  sequence s_zeroed;
    pos_usr == 32'h0 && !zero_valid && mv_ack;
  endsequence

  a_mode_gate: assert property (ce && mv_req && op_mode == OPM_OTHER |=> mv_refuse && !mv_ack) // R1
    else $error("move taken outside range modes");
  a_abs_bound: assert property (ce && mv_req && mv_kind == MV_PP_ABS && !val_in |=> mv_refuse) // R9
    else $error("absolute move outside range taken");
  a_step_zero: assert property (ce && mv_req && !mv_bad && mv_kind == MV_JOG_STEP && rel_out // R7
    |=> pos_usr == 32'h0 && tgt_usr == $past(mv_val))
    else $error("step jog out of range did not zero position");
  a_rel_zero: assert property (s_rel_take |=> s_zeroed) // R8
    else $error("relative move out of range did not zero position");
  a_zero_clear: assert property (ce && step && step_wrap && !mv_req |=> !zero_valid) // R5
    else $error("zero point kept after leaving range");
  a_zero_source: assert property ($rose(zero_valid) |-> $past(mv_req && is_home && op_mode == OPM_HOME)) // R3
    else $error("zero point set without homing");
  a_den_only: assert property (ce && par_wr && hit_den && !div_done |=> $stable(act_den) && $stable(factor)) // R11
    else $error("divisor write changed active scaling");
  a_stage_lock: assert property (ce && par_wr && (hit_num || hit_den) && stage_on // R15
    |=> par_err && $stable(position_scale_multiplier) && $stable(position_scale_divisor))
    else $error("scaling written with power stage on");
  a_wrap_up: assert property (ce && step && !step_neg && op_mode == OPM_JOG && !mv_req // R23
    && pos_usr == `PRS_POS_MAX |=> pos_usr == `PRS_POS_MIN)
    else $error("counter did not wrap to lower bound");
  a_positive_travel_switch_line: assert property (ce && par_wr && hit_io && fn == `PRS_FN_POSITIVE_TRAVEL_SWITCH && io_idx != 2'h0 // R20
    |=> par_err)
    else $error("positive switch accepted on wrong line");
endmodule // prs_top
`default_nettype wire

// *** prs_host.sv ***
// prs_host.sv: fieldbus master model driving the parameter port
// assumes the parameter port of prs_top, inputs changed at the falling edge
`timescale 1ns/1ns
`default_nettype none
module prs_host
(
  input  wire logic        core_clk,
  input  wire logic        par_ack,
  input  wire logic        par_err,
  input  wire logic [31:0] par_rdata,
  output logic             par_wr,
  output logic             par_rd,
  output logic [15:0]      par_addr,
  output logic [31:0]      par_wdata
);
  // ==========================================
  // idle state, released lines never show the last value
  initial
  begin
    par_wr    = 1'b0;
    par_rd    = 1'b0;
    par_addr  = 16'h0000;
    par_wdata = 32'h0000_0000;
  end
  // ==========================================
  // one word written, answer taken one cycle later
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic e);
    @(negedge core_clk);
    par_wr    = 1'b1;
    par_addr  = a;
    par_wdata = d;
    @(negedge core_clk);
    par_wr    = 1'b0;
    e         = par_err | ~par_ack;
    par_addr  = ~par_addr;
    par_wdata = ~par_wdata;
  endtask
  // ==========================================
  // one word read
  task automatic rd(input logic [15:0] a, output logic [31:0] q, output logic e);
    @(negedge core_clk);
    par_rd   = 1'b1;
    par_addr = a;
    @(negedge core_clk);
    par_rd   = 1'b0;
    q        = par_rdata;
    e        = par_err | ~par_ack;
    par_addr = ~par_addr;
  endtask
endmodule // prs_host
`default_nettype wire

// *** position_range_scaling_io_assign_tb.sv ***
// position_range_scaling_io_assign_tb.sv: self-checking bench of prs_top
// assumes prs_pkg, prs_defines.svh and prs_host compiled before
`timescale 1ns/1ns
`default_nettype none
`include "prs_defines.svh"
module position_range_scaling_io_assign_tb
  import prs_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        stage_on = 1'b0;
  prs_mode_t   op_mode  = OPM_OTHER;
  logic        mv_req   = 1'b0;
  prs_move_t   mv_kind  = MV_JOG_CONT;
  logic [31:0] mv_val   = 32'h0;
  logic        step     = 1'b0;
  logic        step_neg = 1'b0;
  logic [3:0]  line_in  = 4'h0;
  logic        ce       = 1'b1;
  wire logic        par_wr, par_rd, par_ack, par_err, mv_ack, mv_refuse, zero_valid, halt_req;
  wire logic [15:0] par_addr;
  wire logic [31:0] par_wdata, par_rdata, tgt_usr, tgt_inc, pos_usr;
  wire logic [3:0]  local_line_state;
  wire logic        positive_travel_switch, negative_travel_switch, ref_switch;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  logic        e;
  logic [31:0] q;
  // ==========================================
  // clock, timeout
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end
  // ==========================================
  // instances
  prs_host u_prs_host (.core_clk(core_clk), .par_ack(par_ack), .par_err(par_err), .par_rdata(par_rdata),
    .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata));
  prs_top u_prs_top (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .stage_on(stage_on),
    .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata), .par_ack(par_ack),
    .par_err(par_err), .par_rdata(par_rdata), .op_mode(op_mode), .mv_req(mv_req), .mv_kind(mv_kind),
    .mv_val(mv_val), .mv_ack(mv_ack), .mv_refuse(mv_refuse), .tgt_usr(tgt_usr), .tgt_inc(tgt_inc),
    .step(step), .step_neg(step_neg), .pos_usr(pos_usr), .zero_valid(zero_valid), .halt_req(halt_req),
    .line_in(line_in), .local_line_state(local_line_state), .positive_travel_switch(positive_travel_switch),
    .negative_travel_switch(negative_travel_switch), .ref_switch(ref_switch));
  // ==========================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrc(input logic [15:0] a, input logic [31:0] d, input logic exp_e);
    u_prs_host.wr(a, d, e);
    chk("write refusal", {31'h0, e}, {31'h0, exp_e});
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    u_prs_host.rd(a, q, e);
    chk("read data", q, exp);
    chk("read refusal", {31'h0, e}, 32'h0);
  endtask
  task automatic calc_wait();
    int n;
    n = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && n < 100)
    begin
      u_prs_host.rd(`PRS_ADDR_FLAG, q, e);
      n = n + 1;
    end
    chk("factor calc end", {31'h0, q[1]}, 32'h0);
  endtask
  task automatic mv(input prs_mode_t m, input prs_move_t k, input logic [31:0] v, input logic acc);
    @(negedge core_clk);
    op_mode = m;
    mv_kind = k;
    mv_val  = v;
    mv_req  = 1'b1;
    @(negedge core_clk);
    mv_req  = 1'b0;
    mv_val  = ~v;
    chk("move ack", {31'h0, mv_ack}, {31'h0, acc});
    chk("move refuse", {31'h0, mv_refuse}, {31'h0, ~acc});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    rdc(`PRS_ADDR_DEN, 32'h0000_4000);
    rdc(`PRS_ADDR_NUM, 32'h0000_0001);
    rdc(`PRS_ADDR_FACT, 32'h0002_0000);
    rdc(`PRS_ADDR_IO1, 32'h15);
    rdc(`PRS_ADDR_IO1 + 16'h2, 32'h16);
    rdc(`PRS_ADDR_IO1 + 16'h4, 32'h1);
    rdc(`PRS_ADDR_IO1 + 16'h6, 32'h14);
    rdc(`PRS_ADDR_FLAG, 32'h0);
    u_prs_host.rd(16'h0100, q, e);
    chk("unmapped data", q, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    $display("test reset done");
    line_in = 4'b0110;
    repeat (2) @(negedge core_clk);
    chk("line state", {28'h0, local_line_state}, 32'h4);
    chk("negative switch", {31'h0, negative_travel_switch}, 32'h1);
    chk("positive switch", {31'h0, positive_travel_switch}, 32'h0);
    chk("reference switch", {31'h0, ref_switch}, 32'h0);
    wrc(`PRS_ADDR_IO1 + 16'h2, 32'h15, 1'b1);
    wrc(`PRS_ADDR_IO1, 32'h16, 1'b1);
    wrc(`PRS_ADDR_IO1, 32'h1, 1'b0);
    line_in = 4'b1111;
    repeat (2) @(negedge core_clk);
    chk("line state", {28'h0, local_line_state}, 32'h5);
    chk("freed positive switch", {31'h0, positive_travel_switch}, 32'h0);
    chk("reference switch on", {31'h0, ref_switch}, 32'h1);
    $display("test lines done");
    stage_on = 1'b1;
    wrc(`PRS_ADDR_DEN, 32'h0000_8000, 1'b1);
    wrc(`PRS_ADDR_NUM, 32'h0000_0002, 1'b1);
    stage_on = 1'b0;
    wrc(`PRS_ADDR_DEN, 32'h0, 1'b1);
    wrc(`PRS_ADDR_DEN, 32'h8000_0000, 1'b1);
    wrc(`PRS_ADDR_NUM, 32'h0, 1'b1);
    wrc(`PRS_ADDR_DEN, 32'h0000_8000, 1'b0);
    rdc(`PRS_ADDR_DEN, 32'h0000_8000);
    rdc(`PRS_ADDR_FACT, 32'h0002_0000);
    wrc(`PRS_ADDR_NUM, 32'h1, 1'b0);
    calc_wait();
    rdc(`PRS_ADDR_FACT, 32'h0001_0000);
    $display("test scaling done");
    mv(OPM_OTHER, MV_JOG_STEP, 32'h10, 1'b0);
    mv(OPM_JOG, MV_PP_ABS, 32'h10, 1'b0);
    mv(OPM_JOG, MV_JOG_STEP, 32'h4000_0000, 1'b1);
    chk("step jog pos", pos_usr, 32'h0);
    chk("step jog tgt", tgt_usr, 32'h4000_0000);
    chk("step jog inc", tgt_inc, 32'h4000_0000);
    mv(OPM_HOME, MV_HOME_SET, 32'h3fff_fffe, 1'b1);
    chk("set pos", pos_usr, 32'h3fff_fffe);
    chk("set zero", {31'h0, zero_valid}, 32'h1);
    op_mode = OPM_JOG;
    step    = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("wrap pos", pos_usr, 32'hc000_0000);
    chk("wrap zero", {31'h0, zero_valid}, 32'h0);
    chk("wrap halt", {31'h0, halt_req}, 32'h0);
    step    = 1'b0;
    mv(OPM_HOME, MV_HOME_REF, 32'h5, 1'b1);
    chk("ref zero", {31'h0, zero_valid}, 32'h1);
    mv(OPM_JOG, MV_JOG_CONT, 32'h77, 1'b1);
    chk("cont tgt", tgt_usr, 32'h5);
    chk("cont pos", pos_usr, 32'h5);
    mv(OPM_PPOS, MV_PP_ABS, 32'h4000_0000, 1'b0);
    mv(OPM_PPOS, MV_PP_ABS, 32'h100, 1'b1);
    chk("abs tgt", tgt_usr, 32'h100);
    mv(OPM_PPOS, MV_PP_REL, 32'h3fff_ffff, 1'b1);
    chk("rel pos", pos_usr, 32'h0);
    chk("rel tgt", tgt_usr, 32'h3fff_ffff);
    chk("rel zero", {31'h0, zero_valid}, 32'h0);
    $display("test moves done");
    wrc(`PRS_ADDR_DEN, 32'h0001_0000, 1'b0);
    wrc(`PRS_ADDR_NUM, 32'h1, 1'b0);
    calc_wait();
    rdc(`PRS_ADDR_FACT, 32'h0000_8000);
    mv(OPM_JOG, MV_JOG_STEP, 32'h4000_0000, 1'b0);
    mv(OPM_PPOS, MV_PP_REL, 32'h4000_0000, 1'b0);
    mv(OPM_HOME, MV_HOME_SET, 32'hc000_0000, 1'b1);
    op_mode  = OPM_JOG;
    step_neg = 1'b1;
    step     = 1'b1;
    @(negedge core_clk);
    chk("down wrap pos", pos_usr, 32'h3fff_ffff);
    chk("small wrap halt", {31'h0, halt_req}, 32'h1);
    step_neg = 1'b0;
    ce       = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("frozen pos", pos_usr, 32'h3fff_ffff);
    step     = 1'b0;
    ce       = 1'b1;
    $display("test small ratio done");
    tally_and_finish();
  end
endmodule // position_range_scaling_io_assign_tb
`default_nettype wire
